/* File: rtl/event_out_chan.sv */
// One event output channel: optional resync, pulse stretch, polarity and enable.
`timescale 1ns/1ps
module event_out_chan (
  input wire logic clock,
  input wire logic rst,
  evt_chan_if.chan ch
);
  import pwm_combo_pkg::*;

  logic       src_d_r;
  logic       base_prev_r;
  logic [3:0] cnt_r;
  logic       evt_r;
  logic       base;
  logic       stretch_en;
  logic       active;

  // With resync the source takes one more system clock stage.
  assign base       = ch.sysclk_sync ? src_d_r : ch.src;
  // Stretching by system clocks still applies when resync is on.
  assign stretch_en = ~ch.suppress | ch.sysclk_sync;
  assign active     = base | (stretch_en & (cnt_r != 4'h0));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      src_d_r     <= 1'b0;
      base_prev_r <= 1'b0;
    end else begin
      src_d_r     <= ch.src;
      base_prev_r <= base;
    end
  end

  // The count starts on the rising edge so the pulse spans eight clocks in total.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
    end else if (base & ~base_prev_r) begin
      cnt_r <= STRETCH_LOAD;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  // Disabled output rests at its inactive level for the chosen polarity.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      evt_r <= 1'b0;
    end else if (ch.enable) begin
      evt_r <= active ^ ch.invert;
    end else begin
      evt_r <= ch.invert;
    end
  end

  assign ch.evt = evt_r;

endmodule // event_out_chan

/* File: rtl/evt_chan_if.sv */
// Signals between the register block and one event output channel.
`timescale 1ns/1ps
interface evt_chan_if;
  logic src;
  logic enable;
  logic invert;
  logic suppress;
  logic sysclk_sync;
  logic evt;

  modport ctrl (output src, output enable, output invert, output suppress,
                output sysclk_sync, input evt);
  modport chan (input src, input enable, input invert, input suppress,
                input sysclk_sync, output evt);
endinterface

/* File: rtl/pwm_combo_event.sv */
// PWM combination logic and event output stage with an APB register slave.
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps

module pwm_combo_event (
  input  wire logic                                      clock,
  input  wire logic                                      rst,
  input  wire logic                                      psel,
  input  wire logic                                      penable,
  input  wire logic                                      pwrite,
  input  wire logic [pwm_combo_pkg::ADDR_W-1:0]          paddr,
  input  wire logic [31:0]                               pwdata,
  output logic      [31:0]                               prdata,
  output logic                                           pready,
  output logic                                           pslverr,
  input  wire logic [pwm_combo_pkg::N_PAIR-1:0]          pair_high_in,
  input  wire logic [pwm_combo_pkg::N_PAIR-1:0]          pair_low_in,
  input  wire logic [pwm_combo_pkg::N_GEN*pwm_combo_pkg::N_EVKIND-1:0] gen_event_in,
  output logic      [pwm_combo_pkg::N_PAIR-1:0]          pair_high_pin,
  output logic      [pwm_combo_pkg::N_PAIR-1:0]          pair_low_pin,
  output logic      [pwm_combo_pkg::N_EVT-1:0]           event_out
);
  import pwm_combo_pkg::*;

  localparam int N_SRC = N_GEN * N_EVKIND;

  typedef enum logic [0:0] {
    ST_SETUP = 1'b0,
    ST_ACK   = 1'b1
  } apb_state_t;

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------

  // Returns {valid, index} for a register bank starting at base.
  function automatic logic [3:0] bank_slot(input logic [ADDR_W-1:0] addr,
                                           input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] diff;
    diff = addr - base;
    if (addr >= base && diff[1:0] == 2'h0 && diff[ADDR_W-1:2] < (ADDR_W-2)'(N_LOGIC)) begin
      bank_slot = {1'b1, diff[4:2]};
    end else begin
      bank_slot = 4'h0;
    end
  endfunction

  // Picks a pair pin by source code; reserved codes and absent pairs read zero.
  function automatic logic pick_pin(input logic [3:0]        code,
                                    input logic [N_PAIR-1:0] hi,
                                    input logic [N_PAIR-1:0] lo);
    logic [1:0] pair;
    pair = code[2:1];
    if (code > SRC_MAX) begin
      pick_pin = 1'b0;
    end else if (!GEN_PRESENT[pair]) begin
      pick_pin = 1'b0;
    end else begin
      pick_pin = code[0] ? lo[pair] : hi[pair];
    end
  endfunction

  // Maps an event select code to its per-generator source index.
  function automatic logic [3:0] evt_kind(input logic [3:0] sel);
    case (sel)
      SEL_GEN_OUT: evt_kind = 4'h8;
      SEL_SYNC:    evt_kind = 4'h9;
      SEL_FF:      evt_kind = 4'ha;
      SEL_CL:      evt_kind = 4'hb;
      SEL_FAULT:   evt_kind = 4'hc;
      SEL_ADC1:    evt_kind = 4'hd;
      SEL_ADC2:    evt_kind = 4'he;
      SEL_HR_ERR:  evt_kind = 4'hf;
      default:     evt_kind = 4'h0;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // Registers and APB slave
  // ---------------------------------------------------------------------------

  logic [15:0]       logcon_r [N_LOGIC];
  logic [15:0]       evtcon_r [N_EVT];
  apb_state_t        state_r;
  logic [31:0]       prdata_r;
  logic              pready_r;
  logic              pslverr_r;
  logic [3:0]        log_slot;
  logic [3:0]        evt_slot;
  logic              stat_hit;
  logic              wr_take;
  logic [31:0]       rd_nxt;
  logic [N_PAIR-1:0] hi_pin_r;
  logic [N_PAIR-1:0] lo_pin_r;
  logic [N_EVT-1:0]  evt_out_r;

  assign log_slot = bank_slot(paddr, LOGCON_BASE);
  assign evt_slot = bank_slot(paddr, EVTCON_BASE);
  assign stat_hit = (paddr == STATUS_OFS);
  // A write lands only at the edge where the master sees pready high.
  assign wr_take  = psel & penable & pwrite & pready_r;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (log_slot[3]) begin
      rd_nxt = {16'h0000, logcon_r[log_slot[2:0]]};
    end else if (evt_slot[3]) begin
      rd_nxt = {16'h0000, evtcon_r[evt_slot[2:0]]};
    end else if (stat_hit) begin
      rd_nxt[STAT_EVT_LSB +: N_EVT] = evt_out_r;
      rd_nxt[STAT_HI_LSB +: N_PAIR] = hi_pin_r;
      rd_nxt[STAT_LO_LSB +: N_PAIR] = lo_pin_r;
    end
  end

  // Every access takes two access-phase cycles; pready is a registered answer.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r   <= ST_SETUP;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      case (state_r)
        ST_SETUP: begin
          if (psel && penable) begin
            state_r   <= ST_ACK;
            pready_r  <= 1'b1;
            pslverr_r <= ~(log_slot[3] | evt_slot[3] | (stat_hit & ~pwrite));
            prdata_r  <= pwrite ? 32'h0000_0000 : rd_nxt;
          end
        end
        ST_ACK: begin
          state_r   <= ST_SETUP;
          pready_r  <= 1'b0;
          pslverr_r <= 1'b0;
        end
        default: begin
          state_r  <= ST_SETUP;
          pready_r <= 1'b0;
        end
      endcase
    end
  end

  generate
    for (genvar i = 0; i < N_LOGIC; i++) begin : g_regs
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          logcon_r[i] <= LOGCON_RESET;
          evtcon_r[i] <= EVTCON_RESET;
        end else if (wr_take) begin
          if (log_slot == {1'b1, 3'(i)}) begin
            logcon_r[i] <= pwdata[15:0] & LOGCON_WMASK;
          end
          if (evt_slot == {1'b1, 3'(i)}) begin
            evtcon_r[i] <= pwdata[15:0] & EVTCON_WMASK;
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Combination pin logic and pin registers
  // ---------------------------------------------------------------------------

  logic [N_LOGIC-1:0] logic_result;
  logic [N_PAIR-1:0]  hi_pin_nxt;
  logic [N_PAIR-1:0]  lo_pin_nxt;

  always_comb begin
    logic a;
    logic b;
    logic [15:0] c;
    a = 1'b0;
    b = 1'b0;
    c = 16'h0000;
    for (int i = 0; i < N_LOGIC; i++) begin
      c = logcon_r[i];
      a = pick_pin(c[SRC1_LSB +: 4], pair_high_in, pair_low_in) ^ c[SRC1_INV];
      b = pick_pin(c[SRC2_LSB +: 4], pair_high_in, pair_low_in) ^ c[SRC2_INV];
      case (c[FUNC_LSB +: 2])
        FUNC_OR:  logic_result[i] = a | b;
        FUNC_AND: logic_result[i] = a & b;
        FUNC_XOR: logic_result[i] = a ^ b;
        default:  logic_result[i] = 1'b0;
      endcase
    end
  end

  // Later instances are visited first so the lowest letter wins a shared pin.
  always_comb begin
    logic [2:0] d;
    d          = DEST_NONE;
    hi_pin_nxt = pair_high_in;
    lo_pin_nxt = pair_low_in;
    for (int i = N_LOGIC - 1; i >= 0; i--) begin
      d = logcon_r[i][DEST_LSB +: 3];
      if (d != DEST_NONE && d <= DEST_MAX) begin
        if (i % 2 == 0) begin
          hi_pin_nxt[d[1:0]] = logic_result[i];
        end else begin
          lo_pin_nxt[d[1:0]] = logic_result[i];
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hi_pin_r <= '0;
      lo_pin_r <= '0;
    end else begin
      hi_pin_r <= hi_pin_nxt;
      lo_pin_r <= lo_pin_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Event source synchronisers
  // ---------------------------------------------------------------------------

  // Generator signals come from their own clocks, so each passes three stages.
  logic [N_SRC-1:0] s1_r;
  logic [N_SRC-1:0] s2_r;
  logic [N_SRC-1:0] s3_r;
  logic [N_SRC-1:0] qual_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_r   <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
      qual_r <= '0;
    end else begin
      s1_r   <= gen_event_in;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      qual_r <= (s2_r & s3_r) | (qual_r & (s2_r | s3_r));
    end
  end

  // ---------------------------------------------------------------------------
  // Event output channels
  // ---------------------------------------------------------------------------

  generate
    for (genvar e = 0; e < N_EVT; e++) begin : g_evt
      evt_chan_if ch ();
      logic [15:0] ec;
      logic [2:0]  gsel;
      logic [3:0]  kind;
      assign ec   = evtcon_r[e];
      assign gsel = ec[EVT_PGS_LSB +: 3];
      assign kind = evt_kind(ec[EVT_SEL_LSB +: 4]);
      // Reserved codes and absent generators leave the source low.
      assign ch.src = (gsel <= PGS_MAX) && GEN_PRESENT[gsel[1:0]] && kind[3]
                      && qual_r[{gsel[1:0], kind[2:0]}];
      assign ch.enable      = ec[EVT_OEN];
      assign ch.invert      = ec[EVT_POL];
      assign ch.suppress    = ec[EVT_STRD];
      assign ch.sysclk_sync = ec[EVT_SYNC];
      assign evt_out_r[e]   = ch.evt;

      event_out_chan u_chan (
        .clock (clock),
        .rst   (rst),
        .ch    (ch.chan)
      );
    end
  endgenerate

  assign prdata        = prdata_r;
  assign pready        = pready_r;
  assign pslverr       = pslverr_r;
  assign pair_high_pin = hi_pin_r;
  assign pair_low_pin  = lo_pin_r;
  assign event_out     = evt_out_r;

endmodule // pwm_combo_event

/* File: rtl/pwm_combo_pkg.sv */
// Constants, field layout and codes shared by the PWM combination and event output logic.
package pwm_combo_pkg;

  localparam int N_LOGIC   = 6;
  localparam int N_EVT     = 6;
  localparam int N_PAIR    = 4;
  localparam int N_GEN     = 4;
  localparam int N_EVKIND  = 8;
  localparam int ADDR_W    = 8;

  // Which generators exist; a missing one reads as a constant zero.
  localparam logic [N_GEN-1:0] GEN_PRESENT = 4'hf;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] LOGCON_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] EVTCON_BASE = 8'h18;
  localparam logic [ADDR_W-1:0] STATUS_OFS  = 8'h30;

  localparam logic [15:0] LOGCON_RESET = 16'h0000;
  localparam logic [15:0] EVTCON_RESET = 16'h0000;
  localparam logic [15:0] LOGCON_WMASK = 16'hfff7;
  localparam logic [15:0] EVTCON_WMASK = 16'hf0f7;

  // Combination control fields.
  localparam int SRC1_LSB    = 12;
  localparam int SRC2_LSB    = 8;
  localparam int SRC1_INV    = 7;
  localparam int SRC2_INV    = 6;
  localparam int FUNC_LSB    = 4;
  localparam int DEST_LSB    = 0;

  // Event control fields.
  localparam int EVT_OEN     = 15;
  localparam int EVT_POL     = 14;
  localparam int EVT_STRD    = 13;
  localparam int EVT_SYNC    = 12;
  localparam int EVT_SEL_LSB = 4;
  localparam int EVT_PGS_LSB = 0;

  // Status register layout.
  localparam int STAT_EVT_LSB = 0;
  localparam int STAT_HI_LSB  = 8;
  localparam int STAT_LO_LSB  = 12;

  localparam logic [1:0] FUNC_OR  = 2'h0;
  localparam logic [1:0] FUNC_AND = 2'h1;
  localparam logic [1:0] FUNC_XOR = 2'h2;

  localparam logic [2:0] DEST_NONE = 3'h0;
  localparam logic [2:0] DEST_MAX  = 3'h3;
  localparam logic [3:0] SRC_MAX   = 4'h7;
  localparam logic [2:0] PGS_MAX   = 3'h3;

  // Event select codes and the source index each one maps to.
  localparam logic [3:0] SEL_GEN_OUT = 4'h0;
  localparam logic [3:0] SEL_SYNC    = 4'h1;
  localparam logic [3:0] SEL_FF      = 4'h2;
  localparam logic [3:0] SEL_CL      = 4'h3;
  localparam logic [3:0] SEL_FAULT   = 4'h4;
  localparam logic [3:0] SEL_ADC1    = 4'h8;
  localparam logic [3:0] SEL_ADC2    = 4'h9;
  localparam logic [3:0] SEL_HR_ERR  = 4'hf;

  localparam int STRETCH_CYCLES = 8;
  localparam logic [3:0] STRETCH_LOAD = 4'(STRETCH_CYCLES - 1);

endpackage

/* File: sim/pwm_combo_checker_properties.sv */
// Port-level properties of the PWM combination and event block.
`timescale 1ns/1ps
module pwm_combo_checker (
  input wire logic                              clock,
  input wire logic                              rst,
  input wire logic                              psel,
  input wire logic                              penable,
  input wire logic                              pwrite,
  input wire logic [pwm_combo_pkg::ADDR_W-1:0]  paddr,
  input wire logic [31:0]                       prdata,
  input wire logic                              pready,
  input wire logic                              pslverr,
  input wire logic [3:0]                        pair_high_in,
  input wire logic [3:0]                        pair_low_in,
  input wire logic [3:0]                        pair_high_pin,
  input wire logic [3:0]                        pair_low_pin,
  input wire logic [5:0]                        event_out
);
  import pwm_combo_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  property p_ready_wait;
    $rose(penable) && psel |-> !pready ##1 pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready not after one wait");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_no_ready_idle;
    !(psel && penable) |-> !pready && !pslverr;
  endproperty
  a_no_ready_idle: assert property (p_no_ready_idle) else $error("answer outside access");
  property p_err_refused;
    pready && (paddr > STATUS_OFS || (pwrite && paddr == STATUS_OFS)) |-> pslverr;
  endproperty
  a_err_refused: assert property (p_err_refused) else $error("refused access not flagged");
  property p_ok_mapped;
    pready && paddr[1:0] == 2'h0 && paddr < STATUS_OFS |-> !pslverr;
  endproperty
  a_ok_mapped: assert property (p_ok_mapped) else $error("mapped access flagged");
  property p_rd_upper;
    pready && !pwrite |-> prdata[31:16] == 16'h0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits not zero");
  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  property p_pair_one;
    1'b1 |=> pair_high_pin[0] == $past(pair_high_in[0]) && pair_low_pin[0] == $past(pair_low_in[0]);
  endproperty
  a_pair_one: assert property (p_pair_one) else $error("pair one pins altered");
  // Without bus traffic the configuration cannot move, so steady inputs give steady pins.
  property p_pin_steady;
    !psel ##1 (!psel && $stable(pair_high_in) && $stable(pair_low_in))
      |=> $stable(pair_high_pin) && $stable(pair_low_pin);
  endproperty
  a_pin_steady: assert property (p_pin_steady) else $error("pins moved without cause");
  c_write: cover property (pready && pwrite && !pslverr);
  c_read: cover property (pready && !pwrite && !pslverr);
  c_refused: cover property (pready && pslverr);
  c_event: cover property ($rose(event_out[0]));
endmodule // pwm_combo_checker

bind pwm_combo_event pwm_combo_checker u_pwm_combo_checker (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pair_high_in(pair_high_in), .pair_low_in(pair_low_in),
  .pair_high_pin(pair_high_pin), .pair_low_pin(pair_low_pin), .event_out(event_out));

/* File: sim/pwm_combo_logic_event_out_bench.sv */
// Self-checking bench for the PWM combination and event block.
`timescale 1ns/1ps
module pwm_combo_logic_event_out_bench;
  import pwm_combo_pkg::*;
  logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, pin_val = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, gen_event_in, rdv;
  logic pready, pslverr, ev_go = 1'b0, erv;
  logic [4:0] ev_idx = 5'h00, ev_len = 5'h00;
  logic [3:0] pair_high_in, pair_low_in, pair_high_pin, pair_low_pin;
  logic [5:0] event_out;
  logic [15:0] seed = 16'h0011, r, cfg;
  int err_total = 0, total_checks = 0, cyc = 0;
  always #2 clock = ~clock;
  pwm_gen_model u_pwm_gen_model (.clock(clock), .rst(rst), .pin_val(pin_val), .ev_go(ev_go),
    .ev_idx(ev_idx), .ev_len(ev_len), .pair_high_in(pair_high_in),
    .pair_low_in(pair_low_in), .gen_event_in(gen_event_in));
  pwm_combo_event u_pwm_combo_event (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pair_high_in(pair_high_in), .pair_low_in(pair_low_in),
    .gen_event_in(gen_event_in), .pair_high_pin(pair_high_pin),
    .pair_low_pin(pair_low_pin), .event_out(event_out));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] nxt();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  function automatic logic src(logic [3:0] s, logic [7:0] pv);
    return s[3] ? 1'b0 : pv[{s[0], s[2:1]}];
  endfunction
  function automatic logic [7:0] exp_pins(logic [15:0] c, int inst, logic [7:0] pv);
    logic a, b, q;
    logic [7:0] e;
    e = pv;
    a = src(c[15:12], pv) ^ c[7];
    b = src(c[11:8], pv) ^ c[6];
    case (c[5:4])
      2'h0: q = a | b;
      2'h1: q = a & b;
      2'h2: q = a ^ b;
      default: q = 1'b0;
    endcase
    if (!c[2] && c[1:0] != 2'h0) e[{inst[0], c[1:0]}] = q;
    return e;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // The answer is sampled at the rising edge itself; only the bench timeout ends a wait.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic give_verdict();
    if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int ch, cnt, lo, hi, len;
    logic [3:0] sel;
    logic [2:0] k;
    logic [7:0] a, pv;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 12; i++) begin
      a = 8'(4 * i);
      apb(1'b0, a, 32'h0000_0000);
      chk(rdv, 32'h0000_0000);
      apb(1'b1, a, 32'hffff_ffff);
      apb(1'b0, a, 32'h0000_0000);
      chk(rdv, {16'h0000, (i < 6) ? LOGCON_WMASK : EVTCON_WMASK});
      apb(1'b1, a, 32'h0000_0000);
    end
    for (int i = 0; i < 40; i++) begin
      r = nxt();
      cfg = {r[15] & r[3], r[14:12], r[11] & r[3], r[10:6], i[1:0], 1'b0,
             (i < 8) ? i[2:0] : {1'b0, r[1:0]}};
      r = nxt();
      pv = r[7:0];
      a = LOGCON_BASE + 8'(4 * (i % 6));
      apb(1'b1, a, {16'h0000, cfg});
      pin_val <= pv;
      repeat (3) @(posedge clock);
      @(negedge clock);
      chk({pair_low_pin, pair_high_pin}, exp_pins(cfg, i % 6, pv));
      @(posedge clock);
      apb(1'b1, a, 32'h0000_0000);
    end
    repeat (3) @(posedge clock);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk(rdv, {16'h0000, pv, 8'h00});
    apb(1'b1, STATUS_OFS, 32'h0000_0000);
    chk(32'(erv), 32'h1);
    apb(1'b0, 8'h34, 32'h0000_0000);
    chk({rdv[30:0], erv}, 32'h1);
    for (int i = 0; i < 16; i++) begin
      r = nxt();
      ch = i % 6;
      sel = i[3:0];
      k = (sel <= 4'h4) ? sel[2:0] : (sel == SEL_ADC1) ? 3'h5 : (sel == SEL_ADC2) ? 3'h6 : 3'h7;
      cfg = {r[15] | r[11], r[14:12], 4'h0, sel, 1'b0, r[2] & r[3], r[1:0]};
      // The source qualifier drops one-cycle strobes, so every strobe lasts two cycles at least.
      len = int'(r[7:4]) + 2;
      apb(1'b1, EVTCON_BASE + 8'(4 * ch), {16'h0000, cfg});
      repeat (4) @(posedge clock);
      @(negedge clock);
      chk(32'(event_out[ch]), 32'(cfg[14]));
      @(posedge clock);
      ev_idx <= {cfg[1:0], k};
      ev_len <= 5'(len);
      ev_go <= 1'b1;
      @(posedge clock);
      ev_go <= 1'b0;
      cnt = 0;
      repeat (40) begin
        @(negedge clock);
        if (event_out[ch] !== cfg[14]) cnt++;
      end
      lo = 0;
      hi = 0;
      if (cfg[15] && !cfg[2] && (sel <= 4'h4 || sel == SEL_ADC1 || sel == SEL_ADC2 || sel == SEL_HR_ERR)) begin
        lo = len;
        hi = len;
        if (!cfg[13] || cfg[12]) begin
          lo = (len < 8) ? 8 : len;
          hi = lo;
        end
      end
      chk(32'(cnt >= lo && cnt <= hi), 32'h1);
      @(posedge clock);
      apb(1'b1, EVTCON_BASE + 8'(4 * ch), 32'h0000_0000);
    end
    give_verdict();
  end
endmodule // pwm_combo_logic_event_out_bench

/* File: sim/pwm_gen_model.sv */
// Behavioural PWM generators feeding pin levels and event strobes.
`timescale 1ns/1ps
module pwm_gen_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [7:0]  pin_val,
  input  wire logic        ev_go,
  input  wire logic [4:0]  ev_idx,
  input  wire logic [4:0]  ev_len,
  output logic      [3:0]  pair_high_in,
  output logic      [3:0]  pair_low_in,
  output logic      [31:0] gen_event_in
);
  logic [4:0] left_r;
  logic [4:0] idx_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pair_high_in <= 4'h0;
      pair_low_in  <= 4'h0;
      left_r       <= 5'h00;
      idx_r        <= 5'h00;
    end else begin
      pair_high_in <= pin_val[3:0];
      pair_low_in  <= pin_val[7:4];
      if (ev_go) begin
        left_r <= ev_len;
        idx_r  <= ev_idx;
      end else if (left_r != 5'h00) begin
        left_r <= left_r - 5'h01;
      end
    end
  end
  // Bit 0 of each group is the raw generator output, ahead of any override.
  assign gen_event_in = (left_r != 5'h00) ? (32'h0000_0001 << idx_r) : 32'h0000_0000;
endmodule // pwm_gen_model
